// >>> common/mahs_pkg.sv
// Package: constants and types for the hot-swap monitor readout block
`default_nettype none
package mahs_pkg;
   // ----------------------------------------------------------------
   // Clock and update timing
   // ----------------------------------------------------------------
   localparam longint CLK_HZ        = 64'd25_000_000;
   localparam longint UPDATE_MHZ    = 64'd7_300;       // 7.3 Hz, in mHz
   localparam int     UPDATE_CYC    = int'((CLK_HZ * 64'd1000) / UPDATE_MHZ);
   localparam int     SEQ_CW        = 22;
   localparam int     NUM_CHAN      = 3;

   // ----------------------------------------------------------------
   // Converter scaling
   // ----------------------------------------------------------------
   localparam int     RES_W         = 10;
   localparam int     SENSE_FS_UV   = 64_000;          // 64 mV full scale
   localparam int     SENSE_STEP_NV = 62_500;          // 62.5 uV per code
   localparam int     AUX_FS_MV     = 2_560;           // 2.56 V full scale
   localparam int     AUX_STEP_UV   = 2_500;           // 2.5 mV per code

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam int     AW            = 4;
   localparam int     DW            = 8;
   localparam logic [3:0] OFS_STATUS   = 4'h0;
   localparam logic [3:0] OFS_FAULT    = 4'h1;
   localparam logic [3:0] OFS_ALERT_EN = 4'h2;
   localparam logic [3:0] OFS_CTRL     = 4'h3;
   localparam logic [3:0] OFS_SENSE_HI = 4'h4;
   localparam logic [3:0] OFS_SENSE_LO = 4'h5;
   localparam logic [3:0] OFS_AUX2_HI  = 4'h6;
   localparam logic [3:0] OFS_AUX2_LO  = 4'h7;
   localparam logic [3:0] OFS_AUX1_HI  = 4'h8;
   localparam logic [3:0] OFS_AUX1_LO  = 4'h9;
   localparam logic [3:0] OFS_IRQ_STAT = 4'ha;
   localparam logic [3:0] OFS_IRQ_MASK = 4'hb;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int     EXT_FAULT_BIT  = 6;
   localparam int     GPO_LEVEL_BIT  = 6;
   localparam int     SEC_ENABLE_BIT = 3;
   localparam int     HOLD_BIT       = 5;
   localparam int     CFG_LSB        = 6;
   localparam int     IRQ_W          = 2;
   localparam int     IRQ_UPDATE     = 0;
   localparam int     IRQ_EXT_FAULT  = 1;
   localparam logic [7:0] CTRL_RST     = 8'h08;
   localparam logic [7:0] ALERT_EN_RST = 8'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MAHS_PG_PULL_LOW = 2'h0,
      MAHS_PG_HIGH_Z   = 2'h1,
      MAHS_PG_GPO      = 2'h2,
      MAHS_PG_GPI      = 2'h3
   } mahs_pin_cfg_t;

   typedef enum logic [1:0] {CH_SENSE, CH_AUX2, CH_AUX1} mahs_chan_t;

   typedef struct packed {
      logic          wr;
      logic          rd;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } mahs_bus_req_t;

   typedef struct packed {
      logic out;
      logic oe;
   } mahs_pin_drv_t;
endpackage
`default_nettype wire

// >>> rtl/mahs_res_pair.sv
// One 10-bit result held as a pair of byte registers
`timescale 1ns/1ns
`default_nettype none
module mahs_res_pair
   import mahs_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Fresh conversion
   input  wire logic             load,
   input  wire logic [RES_W-1:0] code_in,
   // Software access
   input  wire logic             hold,
   input  wire logic             wr_hi,
   input  wire logic             wr_lo,
   input  wire logic [DW-1:0]    wdata,
   // Held value
   output logic      [RES_W-1:0] code_out
);
   typedef struct packed {
      logic [RES_W-1:0] code;
   } mahs_pair_st_t;

   mahs_pair_st_t q, d;

   // Load from converter unless held; software writes only while held
   always_comb begin
      d = q;
      if (!hold && load) begin
         d.code = code_in;
      end
      if (hold && wr_hi) begin
         d.code[RES_W-1:2] = wdata;
      end
      if (hold && wr_lo) begin
         d.code[1:0] = wdata[DW-1:DW-2];
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign code_out = q.code;
endmodule
`default_nettype wire

// >>> rtl/mahs_monitor.sv
// Monitor readout: converter sequencing, result registers, multi-purpose pin
`timescale 1ns/1ns
`default_nettype none
module mahs_monitor
   import mahs_pkg::*;
#(
   parameter int UPDATE_CYCLES = UPDATE_CYC
)
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // Register port
   input  wire mahs_pkg::mahs_bus_req_t bus_req,
   output logic      [mahs_pkg::DW-1:0] bus_rdata,
   // Converter front end
   input  wire logic [mahs_pkg::RES_W-1:0] adc_code,
   output logic      [1:0]            adc_sel,
   // Other fault monitors and gate side
   input  wire logic [5:0]            other_live,
   input  wire logic                  pg2_ready,
   input  wire logic                  secondary_enable_pin,
   // Multi-purpose pin
   input  wire logic                  power_good_multi_io_in,
   output logic                       power_good_multi_io_out,
   output logic                       power_good_multi_io_oe,
   // Alerts and interrupt
   output logic                       alert_b,
   output logic                       irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam logic [SEQ_CW-1:0] SLOT_LAST =
      SEQ_CW'((UPDATE_CYCLES / NUM_CHAN) - 1);

   typedef struct packed {
      logic [SEQ_CW-1:0] cnt;
      mahs_chan_t        chan;
      logic [RES_W-1:0]  sh_sense;
      logic [RES_W-1:0]  sh_aux2;
      logic [RES_W-1:0]  sh_aux1;
      logic              seq_done;
      logic [7:0]        fault;
      logic [7:0]        alert_en;
      logic [7:0]        ctrl;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_mask;
      logic              ext_live;
      logic              sec_pin_prev;
      logic [DW-1:0]     rdata;
      mahs_pin_drv_t     pin;
      logic              alert_b;
      logic              irq;
   } mahs_mon_st_t;

   mahs_mon_st_t q, d;

   logic [RES_W-1:0] res_sense, res_aux2, res_aux1;
   logic             hold;
   mahs_pin_cfg_t    cfg;
   logic             wr_sense_hi, wr_sense_lo;
   logic             wr_aux2_hi, wr_aux2_lo;
   logic             wr_aux1_hi, wr_aux1_lo;

   // ----------------------------------------------------------------
   // Decoded controls
   // ----------------------------------------------------------------
   assign hold = q.ctrl[HOLD_BIT];
   assign cfg  = mahs_pin_cfg_t'(q.ctrl[CFG_LSB +: 2]);

   // Result pair write strobes
   assign wr_sense_hi = bus_req.wr && (bus_req.addr == OFS_SENSE_HI);
   assign wr_sense_lo = bus_req.wr && (bus_req.addr == OFS_SENSE_LO);
   assign wr_aux2_hi  = bus_req.wr && (bus_req.addr == OFS_AUX2_HI);
   assign wr_aux2_lo  = bus_req.wr && (bus_req.addr == OFS_AUX2_LO);
   assign wr_aux1_hi  = bus_req.wr && (bus_req.addr == OFS_AUX1_HI);
   assign wr_aux1_lo  = bus_req.wr && (bus_req.addr == OFS_AUX1_LO);

   // ----------------------------------------------------------------
   // Result register pairs
   // ----------------------------------------------------------------
   // Sense pair first, then aux two, then aux one
   mahs_res_pair u_res_sense (
      .clk      (clk),
      .rst_b    (rst_b),
      .load     (q.seq_done),
      .code_in  (q.sh_sense),
      .hold     (hold),
      .wr_hi    (wr_sense_hi),
      .wr_lo    (wr_sense_lo),
      .wdata    (bus_req.wdata),
      .code_out (res_sense)
   );

   mahs_res_pair u_res_aux2 (
      .clk      (clk),
      .rst_b    (rst_b),
      .load     (q.seq_done),
      .code_in  (q.sh_aux2),
      .hold     (hold),
      .wr_hi    (wr_aux2_hi),
      .wr_lo    (wr_aux2_lo),
      .wdata    (bus_req.wdata),
      .code_out (res_aux2)
   );

   mahs_res_pair u_res_aux1 (
      .clk      (clk),
      .rst_b    (rst_b),
      .load     (q.seq_done),
      .code_in  (q.sh_aux1),
      .hold     (hold),
      .wr_hi    (wr_aux1_hi),
      .wr_lo    (wr_aux1_lo),
      .wdata    (bus_req.wdata),
      .code_out (res_aux1)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] live;
      logic       sec_fall;
      logic       ext_rise;
      logic [7:0] keep;
      logic [IRQ_W-1:0] irq_set;
      live     = '0;
      sec_fall = 1'b0;
      ext_rise = 1'b0;
      keep     = '0;
      irq_set  = '0;
      d = q;
      d.seq_done = 1'b0;

      // Channel sequencer: one slot per channel, fixed order
      if (q.cnt == SLOT_LAST) begin
         d.cnt = '0;
         unique case (q.chan)
            CH_SENSE: begin
               d.sh_sense = adc_code;
               d.chan     = CH_AUX2;
            end
            CH_AUX2: begin
               d.sh_aux2 = adc_code;
               d.chan    = CH_AUX1;
            end
            CH_AUX1: begin
               d.sh_aux1  = adc_code;
               d.chan     = CH_SENSE;
               // Full set ready; pairs drop it while held
               d.seq_done = 1'b1;
            end
            default: begin
               d.chan = CH_SENSE;
            end
         endcase
      end else begin
         d.cnt = q.cnt + SEQ_CW'(1);
      end

      // Live external fault only in input mode
      d.ext_live = (cfg == MAHS_PG_GPI) &&
                   power_good_multi_io_in;
      ext_rise   = d.ext_live && !q.ext_live;

      // Status vector of live conditions
      live = {1'b0, q.ext_live, other_live};

      // Fault register: zero write clears unless still live
      if (bus_req.wr && (bus_req.addr == OFS_FAULT)) begin
         keep    = bus_req.wdata | live;
         d.fault = q.fault & keep;
      end

      // Whole fault register clears on either enable falling
      sec_fall = (q.sec_pin_prev && !secondary_enable_pin) ||
                 (q.ctrl[SEC_ENABLE_BIT] && bus_req.wr &&
                  (bus_req.addr == OFS_CTRL) &&
                  !bus_req.wdata[SEC_ENABLE_BIT]);
      if (sec_fall) begin
         d.fault = '0;
      end
      d.sec_pin_prev = secondary_enable_pin;

      // Live conditions set latched bits, winning over clears
      d.fault = d.fault | live;

      // Control registers
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            OFS_ALERT_EN: d.alert_en = bus_req.wdata;
            OFS_CTRL:     d.ctrl     = bus_req.wdata;
            OFS_IRQ_MASK: d.irq_mask = bus_req.wdata[IRQ_W-1:0];
            OFS_IRQ_STAT: d.irq_stat = q.irq_stat & ~bus_req.wdata[IRQ_W-1:0];
            default:      d.irq_mask = d.irq_mask;
         endcase
      end

      // Interrupt events, set winning over clear
      irq_set[IRQ_UPDATE]    = q.seq_done && !hold;
      irq_set[IRQ_EXT_FAULT] = ext_rise;
      d.irq_stat = d.irq_stat | irq_set;
      d.irq      = |(q.irq_stat & q.irq_mask);

      // Alert excludes the external fault bit
      d.alert_b = !(|(q.fault & q.alert_en &
                      ~(8'h01 << EXT_FAULT_BIT)));

      // Multi-purpose pin drive
      unique case (cfg)
         MAHS_PG_PULL_LOW: begin
            d.pin.out = 1'b0;
            d.pin.oe  = pg2_ready;
         end
         MAHS_PG_HIGH_Z: begin
            d.pin.out = 1'b0;
            d.pin.oe  = !pg2_ready;
         end
         MAHS_PG_GPO: begin
            d.pin.out = q.alert_en[GPO_LEVEL_BIT];
            d.pin.oe  = 1'b1;
         end
         MAHS_PG_GPI: begin
            d.pin.out = 1'b0;
            d.pin.oe  = 1'b0;
         end
      endcase

      // Read data, valid only in the cycle after a read strobe
      d.rdata = '0;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            OFS_STATUS:   d.rdata = live;
            OFS_FAULT:    d.rdata = q.fault;
            OFS_ALERT_EN: d.rdata = q.alert_en;
            OFS_CTRL:     d.rdata = q.ctrl;
            OFS_SENSE_HI: d.rdata = res_sense[RES_W-1:2];
            OFS_SENSE_LO: d.rdata = {res_sense[1:0], 6'h00};
            OFS_AUX2_HI:  d.rdata = res_aux2[RES_W-1:2];
            OFS_AUX2_LO:  d.rdata = {res_aux2[1:0], 6'h00};
            OFS_AUX1_HI:  d.rdata = res_aux1[RES_W-1:2];
            OFS_AUX1_LO:  d.rdata = {res_aux1[1:0], 6'h00};
            OFS_IRQ_STAT: d.rdata = {6'h00, q.irq_stat};
            OFS_IRQ_MASK: d.rdata = {6'h00, q.irq_mask};
            default:      d.rdata = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q          <= '0;
         q.chan     <= CH_SENSE;
         q.ctrl     <= CTRL_RST;
         q.alert_en <= ALERT_EN_RST;
         q.alert_b  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs straight from flops
   // ----------------------------------------------------------------
   assign bus_rdata               = q.rdata;
   assign adc_sel                 = q.chan;
   assign power_good_multi_io_out = q.pin.out;
   assign power_good_multi_io_oe  = q.pin.oe;
   assign alert_b                 = q.alert_b;
   assign irq                     = q.irq;
endmodule
`default_nettype wire

// >>> tb/mahs_monitor_props.sv
// Port checker for the monitor readout block
`timescale 1ns/1ns
`default_nettype none
module mahs_monitor_props
   import mahs_pkg::*;
#(
   parameter int UPDATE_CYCLES = UPDATE_CYC
)
(
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    rst_b,
   // Register port
   input wire mahs_pkg::mahs_bus_req_t bus_req,
   input wire logic [mahs_pkg::DW-1:0] bus_rdata,
   // Converter, pin, alert, interrupt
   input wire logic [1:0]              adc_sel,
   input wire logic                    pg2_ready,
   input wire logic                    power_good_multi_io_out,
   input wire logic                    power_good_multi_io_oe,
   input wire logic                    alert_b,
   input wire logic                    irq
);
   localparam int SLOT = UPDATE_CYCLES / 3;
   logic [1:0] mode_q;
   logic [7:0] ae_q;
   logic [7:0] mk_q;
   logic [1:0] sel_q;
   logic       pg_q;
   int         calm_q;
   int         slot_q;
   logic       calm;
   // Quiet: three cycles without a write, and no ready change seen now
   assign calm = (calm_q >= 3) && (pg2_ready == pg_q);
   // ----
   // Shadows of written fields and counters
   // ----
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= 2'h0;
         ae_q   <= 8'h00;
         mk_q   <= 8'h00;
         sel_q  <= 2'h0;
         pg_q   <= 1'b0;
         calm_q <= 0;
         slot_q <= 0;
      end else begin
         sel_q  <= adc_sel;
         pg_q   <= pg2_ready;
         slot_q <= (adc_sel != sel_q) ? 1 : slot_q + 1;
         calm_q <= (bus_req.wr || pg2_ready != pg_q) ? 0 : (calm ? calm_q : calm_q + 1);
         if (bus_req.wr && bus_req.addr == OFS_CTRL) begin
            mode_q <= bus_req.wdata[7:6];
         end
         if (bus_req.wr && bus_req.addr == OFS_ALERT_EN) begin
            ae_q <= bus_req.wdata;
         end
         if (bus_req.wr && bus_req.addr == OFS_IRQ_MASK) begin
            mk_q <= bus_req.wdata;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
      else $error("read data outside answer cycle");
   AST_SEL_RANGE: assert property (adc_sel != 2'h3)
      else $error("bad channel select");
   AST_SEL_ORDER: assert property ($changed(adc_sel) |->
      adc_sel == (($past(adc_sel) == 2'h2) ? 2'h0 : $past(adc_sel) + 2'h1))
      else $error("channel order broken");
   AST_SEL_STAND: assert property ($changed(adc_sel) |=> $stable(adc_sel) [*8])
      else $error("channel slot too short");
   AST_SEL_SLOT: assert property (slot_q <= SLOT + 1)
      else $error("channel slot too long");
   AST_PIN_PULL_LOW: assert property (calm && mode_q == 2'h0 |->
      power_good_multi_io_oe == pg2_ready && !power_good_multi_io_out)
      else $error("pull-low mode drive wrong");
   AST_PIN_HIGH_Z: assert property (calm && mode_q == 2'h1 |->
      power_good_multi_io_oe == !pg2_ready && !power_good_multi_io_out)
      else $error("high-z mode drive wrong");
   AST_PIN_GPO: assert property (calm && mode_q == 2'h2 |->
      power_good_multi_io_oe && power_good_multi_io_out == ae_q[6])
      else $error("output mode drive wrong");
   AST_PIN_GPI: assert property (calm && mode_q == 2'h3 |-> !power_good_multi_io_oe)
      else $error("input mode drives pin");
   AST_EXT_NO_ALERT: assert property (calm && (ae_q & 8'hbf) == 8'h00 |-> alert_b)
      else $error("alert without enabled fault");
   AST_IRQ_MASKED: assert property (calm && mk_q == 8'h00 |-> !irq)
      else $error("interrupt while all masked");
endmodule

bind mahs_monitor mahs_monitor_props #(.UPDATE_CYCLES(UPDATE_CYCLES)) props_u (
   .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata), .adc_sel(adc_sel),
   .pg2_ready(pg2_ready), .power_good_multi_io_out(power_good_multi_io_out),
   .power_good_multi_io_oe(power_good_multi_io_oe), .alert_b(alert_b), .irq(irq));
`default_nettype wire

// >>> tb/mahs_adc_model.sv
// Converter front-end model: answers the channel select with its code
`timescale 1ns/1ns
`default_nettype none
module mahs_adc_model
   import mahs_pkg::*;
(
   // Clock and select
   input  wire logic                       clk,
   input  wire logic [1:0]                 adc_sel,
   // Codes to present per channel
   input  wire logic [mahs_pkg::RES_W-1:0] sense_code,
   input  wire logic [mahs_pkg::RES_W-1:0] aux2_code,
   input  wire logic [mahs_pkg::RES_W-1:0] aux1_code,
   // Code toward the block
   output logic      [mahs_pkg::RES_W-1:0] adc_code
);
   // Selected channel code; an illegal select gets a toggling pattern
   always_ff @(posedge clk) begin
      case (adc_sel)
         2'h0: adc_code <= sense_code;
         2'h1: adc_code <= aux2_code;
         2'h2: adc_code <= aux1_code;
         default: adc_code <= ~adc_code;
      endcase
   end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the monitor readout block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mahs_pkg::*;
   logic          clk;
   logic          rst_b;
   mahs_bus_req_t req;
   logic [7:0]    rdata;
   logic [9:0]    adc_code;
   logic [1:0]    adc_sel;
   logic [9:0]    sense_c;
   logic [9:0]    aux2_c;
   logic [9:0]    aux1_c;
   logic [5:0]    other_live;
   logic          pg2;
   logic          sec_pin;
   logic          ext_lvl;
   logic          pin_in;
   logic          pin_out;
   logic          pin_oe;
   logic          alert_b;
   logic          irq;
   int            err_total;
   int            checks_done;
   // Pin level: our own drive when enabled, else the outside level
   assign pin_in = pin_oe ? pin_out : ext_lvl;
   mahs_monitor #(.UPDATE_CYCLES(30)) dut_u (
      .clk(clk), .rst_b(rst_b), .bus_req(req), .bus_rdata(rdata),
      .adc_code(adc_code), .adc_sel(adc_sel), .other_live(other_live),
      .pg2_ready(pg2), .secondary_enable_pin(sec_pin), .power_good_multi_io_in(pin_in),
      .power_good_multi_io_out(pin_out), .power_good_multi_io_oe(pin_oe),
      .alert_b(alert_b), .irq(irq));
   mahs_adc_model adc_u (
      .clk(clk), .adc_sel(adc_sel), .sense_code(sense_c), .aux2_code(aux2_c),
      .aux1_code(aux1_c), .adc_code(adc_code));
   // ----
   // Bus cycles and comparisons
   // ----
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      d = rdata;
   endtask
   task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      bus_rd(a, d);
      chk(d, e);
   endtask
   task automatic chk_res(input logic [9:0] s, input logic [9:0] a2, input logic [9:0] a1);
      chk_rd(OFS_SENSE_HI, s[9:2]);
      chk_rd(OFS_SENSE_LO, {s[1:0], 6'h00});
      chk_rd(OFS_AUX2_HI, a2[9:2]);
      chk_rd(OFS_AUX2_LO, {a2[1:0], 6'h00});
      chk_rd(OFS_AUX1_HI, a1[9:2]);
      chk_rd(OFS_AUX1_LO, {a1[1:0], 6'h00});
   endtask
   // Clear the update flag, then poll until a fresh set is loaded
   task automatic wait_upd();
      logic [7:0] d;
      int         n;
      bus_wr(OFS_IRQ_STAT, 8'h01);
      d = 8'h00;
      n = 0;
      while (d[0] !== 1'b1) begin
         bus_rd(OFS_IRQ_STAT, d);
         n++;
         if (n > 100) begin
            err_total++;
            end_of_test();
         end
      end
   endtask
   task automatic pulse();
      @(posedge clk);
      ext_lvl <= 1'b1;
      idle(3);
      @(posedge clk);
      ext_lvl <= 1'b0;
      idle(3);
      chk_rd(OFS_FAULT, 8'h40);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_conv();
      wait_upd();
      wait_upd();
      bus_wr(OFS_AUX1_HI, 8'h33);
      bus_wr(OFS_CTRL, 8'h28);
      chk_res(10'h2a5, 10'h1c3, 10'h3ff);
   endtask
   task automatic t_hold();
      sense_c <= 10'h001;
      aux2_c <= 10'h200;
      aux1_c <= 10'h155;
      idle(70);
      chk_res(10'h2a5, 10'h1c3, 10'h3ff);
      bus_wr(OFS_SENSE_HI, 8'h5a);
      chk_rd(OFS_SENSE_HI, 8'h5a);
      bus_wr(OFS_CTRL, 8'h08);
      wait_upd();
      wait_upd();
      bus_wr(OFS_CTRL, 8'h28);
      chk_res(10'h001, 10'h200, 10'h155);
      bus_wr(OFS_CTRL, 8'h08);
   endtask
   task automatic t_pin();
      logic [7:0] eo;
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            bus_wr(OFS_ALERT_EN, p[0] ? 8'h40 : 8'h00);
            bus_wr(OFS_CTRL, {m[1:0], 6'h08});
            pg2 <= p[0];
            idle(4);
            eo = (m == 0) ? {7'h0, p[0]} : (m == 1) ? {7'h0, !p[0]} : {7'h0, m == 2};
            chk({7'h0, pin_oe}, eo);
            if (m == 2) chk({7'h0, pin_out}, {7'h0, p[0]});
         end
      end
   endtask
   task automatic t_gpi();
      bus_wr(OFS_IRQ_MASK, 8'h02);
      ext_lvl <= 1'b1;
      idle(4);
      chk_rd(OFS_STATUS, 8'h40);
      chk_rd(OFS_FAULT, 8'h40);
      chk({7'h0, alert_b}, 8'h01);
      chk({7'h0, irq}, 8'h01);
      bus_wr(OFS_FAULT, 8'h00);
      chk_rd(OFS_FAULT, 8'h40);
      @(posedge clk);
      ext_lvl <= 1'b0;
      idle(4);
      chk_rd(OFS_STATUS, 8'h00);
      chk_rd(OFS_FAULT, 8'h40);
      bus_wr(OFS_FAULT, 8'h00);
      chk_rd(OFS_FAULT, 8'h00);
      pulse();
      @(posedge clk);
      sec_pin <= 1'b0;
      idle(3);
      chk_rd(OFS_FAULT, 8'h00);
      @(posedge clk);
      sec_pin <= 1'b1;
      pulse();
      bus_wr(OFS_CTRL, 8'hc0);
      chk_rd(OFS_FAULT, 8'h00);
      bus_wr(OFS_IRQ_MASK, 8'h00);
      idle(2);
      chk({7'h0, irq}, 8'h00);
      bus_wr(OFS_IRQ_MASK, 8'h02);
      idle(2);
      chk({7'h0, irq}, 8'h01);
      bus_wr(OFS_IRQ_STAT, 8'h02);
      idle(2);
      chk({7'h0, irq}, 8'h00);
      // Another monitor's fault does raise the alert, and stays while live
      @(posedge clk);
      other_live <= 6'h04;
      bus_wr(OFS_ALERT_EN, 8'h44);
      bus_wr(OFS_FAULT, 8'h00);
      idle(3);
      chk({7'h0, alert_b}, 8'h00);
      chk_rd(OFS_FAULT, 8'h04);
      chk_rd(OFS_ALERT_EN, 8'h44);
      chk_rd(OFS_IRQ_MASK, 8'h02);
   endtask
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Reset, then the scenarios in turn
   initial begin
      rst_b = 1'b0;
      req = '0;
      pg2 = 1'b1;
      sec_pin = 1'b1;
      ext_lvl = 1'b0;
      other_live = 6'h00;
      sense_c = 10'h2a5;
      aux2_c = 10'h1c3;
      aux1_c = 10'h3ff;
      err_total = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      idle(1);
      chk({7'h0, pin_oe}, 8'h01);
      chk_rd(OFS_CTRL, CTRL_RST);
      chk_rd(OFS_FAULT, 8'h00);
      chk_rd(4'hc, 8'h00);
      t_conv();
      t_hold();
      t_pin();
      t_gpi();
      end_of_test();
   end
endmodule
`default_nettype wire
